// file: load_stall_defines.vh
// constants for the motor load measurement and stall detection block
// assumes a 20 MHz system clock and a 32-bit register bus, byte addressed
`ifndef LOAD_STALL_DEFINES_VH
`define LOAD_STALL_DEFINES_VH

`define CLK_PERIOD_NS        32'd50
`define STALL_PULSE_NS       32'd1000
`define STALL_PULSE_CYCLES   ((`STALL_PULSE_NS + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)

`define ADDR_W               8
`define LOAD_W               10
`define LOAD_MAX             10'h3ff
`define OFFSET_W             7
`define OFFSET_SHIFT         3
`define INTERVAL_W           20
`define INTERVAL_MAX         20'hfffff
`define STEPS_PER_PERIOD     2'h3

`define REG_CONFIG           8'h00
`define REG_LOWER_LIMIT      8'h04
`define REG_UPPER_LIMIT      8'h08
`define REG_LOAD_VALUE       8'h0c
`define REG_STEP_INTERVAL    8'h10
`define REG_INT_STATUS       8'h14
`define REG_INT_CLEAR        8'h18
`define REG_INT_ENABLE       8'h1c

`define CFG_OFFSET_LSB       0
`define CFG_OFFSET_MSB       6
`define CFG_FILTER_BIT       8
`define CFG_ROUTE_A_BIT      9
`define CFG_ROUTE_B_BIT      10

`define INT_W                3
`define INT_STALL_BIT        0
`define INT_UPDATE_BIT       1
`define INT_WINDOW_BIT       2

`define RST_CONFIG           11'h000
`define RST_LOWER_LIMIT      20'h00000
`define RST_UPPER_LIMIT      20'h00000
`define RST_LOAD_VALUE       10'h000
`define RST_INT_ENABLE       3'h0

`endif

// file: load_sample_store.v
// four-word store of per-step load readings with a registered sum
// assumes writes arrive one word per enabled clock at most
`timescale 1ns/1ps
`include "load_stall_defines.vh"

module load_sample_store (
  input  wire                 sys_clk,
  input  wire                 rst_n,
  input  wire                 clk_en,
  input  wire                 clear,
  input  wire                 wr_en,
  input  wire [1:0]           wr_idx,
  input  wire [`LOAD_W-1:0]   wr_data,
  output reg  [`LOAD_W+1:0]   sum_out
);

  reg [`LOAD_W-1:0] mem [0:3];
  integer           i;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem[i] <= {`LOAD_W{1'b0}};
      end
      sum_out <= {(`LOAD_W+2){1'b0}};
    end else if (clk_en) begin
      if (clear) begin
        for (i = 0; i < 4; i = i + 1) begin
          mem[i] <= {`LOAD_W{1'b0}};
        end
      end else if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      sum_out <= {2'b00, mem[0]} + {2'b00, mem[1]} + {2'b00, mem[2]} + {2'b00, mem[3]};
    end
  end

endmodule // load_sample_store

// file: motor_load_stall_detect.v
// sensorless load measurement and stall detection with an avalon-mm slave
// assumes step and full-step pulses and raw load samples synchronous to sys_clk
//
// Summary of operation
// - reading saturates to zero when the motor runs at maximum load
// - larger reading means lighter load, zero means the heaviest load
// - signed threshold offset shifts the reading; lower offset, more sensitive
// - filter enable averages four full steps, one result per electrical period
// - stall signal can be routed to either fault pin
// - stall detection suppressed when velocity lies outside the limit window
// - separate upper velocity limit above which detection stops
// - stall gives zero unfiltered reading and a pulse on the routed fault pin
// - unfiltered reading updates once per motor full step
// - reading is a ten-bit unsigned value
`timescale 1ns/1ps
`include "load_stall_defines.vh"

module motor_load_stall_detect (
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  clk_en,
  input  wire                  step_pulse,
  input  wire                  fullstep_pulse,
  input  wire [`LOAD_W-1:0]    raw_load,
  input  wire [`ADDR_W-1:0]    avs_address,
  input  wire                  avs_read,
  input  wire                  avs_write,
  input  wire [31:0]           avs_writedata,
  input  wire [3:0]            avs_byteenable,
  output reg  [31:0]           avs_readdata,
  output reg                   avs_waitrequest,
  output reg                   fault_pin_a,
  output reg                   fault_pin_b,
  output reg                   irq
);

  // pulse length worked out in 32 bits, then cut to the counter width
  localparam [31:0] PULSE_CYCLES_FULL = `STALL_PULSE_CYCLES;
  localparam [5:0]  PULSE_CYCLES      = PULSE_CYCLES_FULL[5:0];

  // filter sequencer states
  localparam [1:0] FS_COLLECT = 2'b00;
  localparam [1:0] FS_SUM     = 2'b01;
  localparam [1:0] FS_TAKE    = 2'b10;

  // configuration and limits
  reg  [10:0]              config_reg;
  reg  [`INTERVAL_W-1:0]   lower_velocity_limit;
  reg  [`INTERVAL_W-1:0]   upper_velocity_limit;
  reg  [`INT_W-1:0]        int_status;
  reg  [`INT_W-1:0]        int_enable;

  // measurement state
  reg  [`LOAD_W-1:0]       load_measurement_value;
  reg  [`INTERVAL_W-1:0]   measured_step_interval;
  reg  [`INTERVAL_W-1:0]   interval_count;
  reg  [1:0]               sample_idx;
  reg  [1:0]               filt_state;
  reg                      filter_on_q;
  reg                      window_q;
  reg  [5:0]               pulse_count;

  wire [`OFFSET_W-1:0]     stall_threshold_offset;
  wire                     filter_en;
  wire                     route_a;
  wire                     route_b;
  wire [`LOAD_W+1:0]       sample_sum;
  wire [`LOAD_W-1:0]       inst_load;
  wire                     window_ok;
  wire                     full_step_evt;
  wire                     stall_trig;
  wire                     bus_write;
  wire                     bus_req;
  wire [`INT_W-1:0]        int_set;
  wire [`INT_W-1:0]        int_clr;
  wire [`INT_W-1:0]        next_int_status;
  reg  [31:0]              next_readdata;
  wire [31:0]              merged_config;
  wire [31:0]              merged_lower;
  wire [31:0]              merged_upper;
  wire                     filter_restart;

  // merge written bytes into a stored word
  function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  be;
    integer      k;
    begin
      merge_bytes = old_word;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge_bytes[k*8 +: 8] = new_word[k*8 +: 8];
        end
      end
    end
  endfunction

  // raw reading plus scaled signed offset, saturated to ten bits
  function [`LOAD_W-1:0] apply_offset;
    input [`LOAD_W-1:0]   raw;
    input [`OFFSET_W-1:0] offset;
    reg   [11:0]          sum;
    begin
      sum = 12'h000;
      sum = {2'b00, raw} + {{2{offset[`OFFSET_W-1]}}, offset, 3'b000};
      if (sum[11]) begin
        apply_offset = {`LOAD_W{1'b0}};
      end else if (sum[10]) begin
        apply_offset = `LOAD_MAX;
      end else begin
        apply_offset = sum[`LOAD_W-1:0];
      end
    end
  endfunction

  // larger step interval means slower motor
  function in_window;
    input [`INTERVAL_W-1:0] interval;
    input [`INTERVAL_W-1:0] lower;
    input [`INTERVAL_W-1:0] upper;
    begin
      // zero lower limit keeps detection off; zero upper limit opens the fast end
      if (lower == {`INTERVAL_W{1'b0}}) begin
        in_window = 1'b0;
      end else begin
        in_window = (interval <= lower) && (interval >= upper);
      end
    end
  endfunction

  assign stall_threshold_offset = config_reg[`CFG_OFFSET_MSB:`CFG_OFFSET_LSB];
  assign filter_en = config_reg[`CFG_FILTER_BIT];
  assign route_a = config_reg[`CFG_ROUTE_A_BIT];
  assign route_b = config_reg[`CFG_ROUTE_B_BIT];

  assign inst_load = apply_offset(raw_load, stall_threshold_offset);
  assign window_ok = in_window(measured_step_interval, lower_velocity_limit,
                               upper_velocity_limit);
  assign full_step_evt = fullstep_pulse;
  // instantaneous per-step value drives stall, so filtering never delays it
  assign stall_trig = full_step_evt && (inst_load == {`LOAD_W{1'b0}}) && window_ok;

  assign bus_req = avs_read || avs_write;
  assign bus_write = avs_write && !avs_waitrequest;
  // toggling the filter throws away a partial group
  assign filter_restart = filter_en != filter_on_q;

  // ---------------- bus slave ----------------

  assign int_clr = (bus_write && (avs_address == `REG_INT_CLEAR))
                   ? avs_writedata[`INT_W-1:0] : {`INT_W{1'b0}};

  assign int_set[`INT_STALL_BIT] = stall_trig;
  assign int_set[`INT_UPDATE_BIT] = (!filter_en && full_step_evt)
                                    || (filter_en && filt_state == FS_TAKE);
  assign int_set[`INT_WINDOW_BIT] = window_ok && !window_q;

  // a set in the same cycle as its clear wins
  assign next_int_status = (int_status & ~int_clr) | int_set;

  // clear register and holes read as zero
  always @* begin
    case (avs_address)
      `REG_CONFIG:        next_readdata = {21'h000000, config_reg};
      `REG_LOWER_LIMIT:   next_readdata = {12'h000, lower_velocity_limit};
      `REG_UPPER_LIMIT:   next_readdata = {12'h000, upper_velocity_limit};
      `REG_LOAD_VALUE:    next_readdata = {22'h000000, load_measurement_value};
      `REG_STEP_INTERVAL: next_readdata = {12'h000, measured_step_interval};
      `REG_INT_STATUS:    next_readdata = {29'h00000000, int_status};
      `REG_INT_ENABLE:    next_readdata = {29'h00000000, int_enable};
      default:            next_readdata = 32'h00000000;
    endcase
  end

  // byte lanes merged at full width, then cut to each register's width
  assign merged_config = merge_bytes({21'h000000, config_reg}, avs_writedata,
                                     avs_byteenable);
  assign merged_lower = merge_bytes({12'h000, lower_velocity_limit}, avs_writedata,
                                    avs_byteenable);
  assign merged_upper = merge_bytes({12'h000, upper_velocity_limit}, avs_writedata,
                                    avs_byteenable);

  // one wait state: answer stands at the second edge of every request
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (bus_req) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? next_readdata : 32'h00000000;
      end
    end
  end

  // writable registers change only at the completing edge
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      config_reg <= `RST_CONFIG;
      lower_velocity_limit <= `RST_LOWER_LIMIT;
      upper_velocity_limit <= `RST_UPPER_LIMIT;
      int_enable <= `RST_INT_ENABLE;
    end else if (clk_en && bus_write) begin
      case (avs_address)
        `REG_CONFIG: begin
          config_reg <= merged_config[10:0];
        end
        `REG_LOWER_LIMIT: begin
          lower_velocity_limit <= merged_lower[`INTERVAL_W-1:0];
        end
        `REG_UPPER_LIMIT: begin
          upper_velocity_limit <= merged_upper[`INTERVAL_W-1:0];
        end
        `REG_INT_ENABLE: begin
          int_enable <= avs_writedata[`INT_W-1:0];
        end
        default: begin
          int_enable <= int_enable;
        end
      endcase
    end
  end

  // ---------------- interrupts ----------------
  // irq updates at the same edge as status; a set beside its clear keeps the bit

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      int_status <= {`INT_W{1'b0}};
      irq <= 1'b0;
      window_q <= 1'b0;
    end else if (clk_en) begin
      int_status <= next_int_status;
      irq <= |(next_int_status & int_enable);
      window_q <= window_ok;
    end
  end

  // ---------------- velocity measurement ----------------

  // saturating interval counter; a stopped motor reads as maximum interval
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      interval_count <= {`INTERVAL_W{1'b0}};
      measured_step_interval <= `INTERVAL_MAX;
    end else if (clk_en) begin
      if (step_pulse) begin
        measured_step_interval <= interval_count;
        interval_count <= {{(`INTERVAL_W-1){1'b0}}, 1'b1};
      end else if (interval_count != `INTERVAL_MAX) begin
        interval_count <= interval_count + {{(`INTERVAL_W-1){1'b0}}, 1'b1};
      end else begin
        measured_step_interval <= `INTERVAL_MAX;
      end
    end
  end

  // ---------------- load measurement and filter ----------------

  load_sample_store u_store (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .clear   (filter_restart),
    .wr_en   (filter_en && full_step_evt),
    .wr_idx  (sample_idx),
    .wr_data (inst_load),
    .sum_out (sample_sum)
  );

  // in filtered mode the fourth sample starts a two-edge sum pipeline
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      load_measurement_value <= `RST_LOAD_VALUE;
      sample_idx <= 2'b00;
      filt_state <= FS_COLLECT;
      filter_on_q <= 1'b0;
    end else if (clk_en) begin
      filter_on_q <= filter_en;
      if (filter_restart) begin
        sample_idx <= 2'b00;
        filt_state <= FS_COLLECT;
      end else if (!filter_en) begin
        if (full_step_evt) begin
          load_measurement_value <= inst_load;
        end
      end else begin
        if (full_step_evt) begin
          sample_idx <= sample_idx + 2'b01;
        end
        case (filt_state)
          FS_COLLECT: begin
            if (full_step_evt && sample_idx == `STEPS_PER_PERIOD) begin
              filt_state <= FS_SUM;
            end
          end
          FS_SUM: begin
            filt_state <= FS_TAKE;
          end
          FS_TAKE: begin
            // four ten-bit samples summed in twelve bits, divided by four
            load_measurement_value <= sample_sum[`LOAD_W+1:2];
            filt_state <= FS_COLLECT;
          end
          default: begin
            filt_state <= FS_COLLECT;
          end
        endcase
      end
    end
  end

  // ---------------- stall output ----------------

  // a fixed-width pulse so a slow controller sees a single event
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pulse_count <= 6'h00;
      fault_pin_a <= 1'b0;
      fault_pin_b <= 1'b0;
    end else if (clk_en) begin
      if (stall_trig) begin
        pulse_count <= PULSE_CYCLES;
        fault_pin_a <= route_a;
        fault_pin_b <= route_b;
      end else begin
        // pin falls after the counter's last cycle, giving the full width
        if (pulse_count != 6'h00) begin
          pulse_count <= pulse_count - 6'h01;
        end
        fault_pin_a <= route_a && (pulse_count > 6'h01);
        fault_pin_b <= route_b && (pulse_count > 6'h01);
      end
    end
  end

endmodule // motor_load_stall_detect

// file: motor_load_stall_props.sv
// assertions on the load and stall block ports
// assumes one clock domain with a synchronous active low reset
`timescale 1ns/1ps
`include "load_stall_defines.vh"

module motor_load_stall_props (
  input wire               sys_clk,
  input wire               rst_n,
  input wire               fullstep_pulse,
  input wire [`LOAD_W-1:0] raw_load,
  input wire [`ADDR_W-1:0] avs_address,
  input wire               avs_read,
  input wire               avs_write,
  input wire [31:0]        avs_readdata,
  input wire               avs_waitrequest,
  input wire               fault_pin_a,
  input wire               fault_pin_b
);
  reg  [4:0] age;
  wire       req = avs_read | avs_write;

  // saturates so a long pause between steps cannot wrap to a small age
  always @(posedge sys_clk) begin
    if (!rst_n)
      age <= 5'h1f;
    else if (fullstep_pulse)
      age <= 5'h01;
    else if (age != 5'h1f)
      age <= age + 5'h01;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_load_width: assert property (!avs_waitrequest && $past(avs_read) &&
    $past(avs_address) == `REG_LOAD_VALUE |-> avs_readdata[31:`LOAD_W] == 22'h0)
    else $error("load reading wider than ten bits");
  chk_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read) &&
    $past(avs_address) > `REG_INT_ENABLE |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rise_a_cause: assert property ($rose(fault_pin_a) |-> $past(fullstep_pulse))
    else $error("pin a rose without a full step");
  chk_rise_b_cause: assert property ($rose(fault_pin_b) |-> $past(fullstep_pulse))
    else $error("pin b rose without a full step");
  chk_stall_raw_low: assert property ($rose(fault_pin_a) |-> $past(raw_load) <= 10'h200)
    else $error("stall on a reading that offset cannot bring to zero");
  chk_pulse_held: assert property (fault_pin_a |-> age <= 5'd20)
    else $error("pin a pulse too long");
  chk_pulse_end: assert property ($fell(fault_pin_a) |-> age == 5'd21)
    else $error("pin a pulse not twenty cycles");

  cov_stall_a: cover property ($rose(fault_pin_a));
  cov_stall_b: cover property ($rose(fault_pin_b));
  cov_write: cover property (!avs_waitrequest && $past(avs_write));
endmodule // motor_load_stall_props

bind motor_load_stall_detect motor_load_stall_props props_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .fullstep_pulse(fullstep_pulse), .raw_load(raw_load),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fault_pin_a(fault_pin_a), .fault_pin_b(fault_pin_b));

// file: motion_ctrl_model.sv
// motion controller model: issues full steps, halts on a stall pulse
// assumes the block samples raw_load in the cycle of fullstep_pulse
`timescale 1ns/1ps

module motion_ctrl_model #(
  parameter PERIOD = 40
) (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire [9:0] raw,
  input  wire [9:0] ramp,
  input  wire       fault_pin_a,
  input  wire       fault_pin_b,
  output reg        step_pulse,
  output reg        fullstep_pulse,
  output reg  [9:0] raw_load,
  output reg        stop_a,
  output reg        stop_b
);
  reg  [7:0] cnt;
  reg  [1:0] idx;
  wire       fire = (cnt == PERIOD - 1) && !stop_a && !stop_b;

  always @(posedge sys_clk) begin
    if (!rst_n || !run) begin
      cnt <= 8'h00;
      idx <= 2'h0;
      stop_a <= 1'b0;
      stop_b <= 1'b0;
      step_pulse <= 1'b0;
      fullstep_pulse <= 1'b0;
      raw_load <= 10'h2aa;
    end else begin
      // one pulse halts the motor, no waiting for repeats
      stop_a <= stop_a | fault_pin_a;
      stop_b <= stop_b | fault_pin_b;
      cnt <= fire ? 8'h00 : cnt + 8'h01;
      step_pulse <= fire;
      fullstep_pulse <= fire;
      idx <= fire ? idx + 2'h1 : idx;
      // sample valid only with the pulse, junk in between
      raw_load <= fire ? raw + ramp * {8'h00, idx} : ~raw_load;
    end
  end
endmodule // motion_ctrl_model

// file: motor_load_stall_detect_tb.sv
// self-checking bench for the load and stall block
// assumes the controller model drives the step side, bench drives the bus
`timescale 1ns/1ps
`include "load_stall_defines.vh"

module motor_load_stall_detect_tb;
  reg                sys_clk, rst_n, run, avs_read, avs_write;
  reg  [`ADDR_W-1:0] avs_address;
  reg  [31:0]        avs_writedata, rdata;
  reg  [`LOAD_W-1:0] raw, ramp;
  wire [31:0]        avs_readdata;
  wire               avs_waitrequest, fault_pin_a, fault_pin_b, irq;
  wire               step_pulse, fullstep_pulse, stop_a, stop_b;
  wire [`LOAD_W-1:0] raw_load;
  integer            failures, checks;

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  motor_load_stall_detect dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .step_pulse(step_pulse), .fullstep_pulse(fullstep_pulse), .raw_load(raw_load),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_pin_a(fault_pin_a),
    .fault_pin_b(fault_pin_b), .irq(irq));

  motion_ctrl_model #(.PERIOD(40)) ctrl_u (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
    .raw(raw), .ramp(ramp), .fault_pin_a(fault_pin_a), .fault_pin_b(fault_pin_b),
    .step_pulse(step_pulse), .fullstep_pulse(fullstep_pulse), .raw_load(raw_load),
    .stop_a(stop_a), .stop_b(stop_b));

  task test_done;
    begin
      if (failures == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // trailing edge keeps back to back calls from driving twice in one step
  task bus(input wr, input [`ADDR_W-1:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task wr(input [`ADDR_W-1:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd_chk(input string what, input [`ADDR_W-1:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      check(what, rdata, exp);
    end
  endtask

  task steps(input integer n);
    begin
      repeat (n) begin
        @(posedge sys_clk);
        while (fullstep_pulse !== 1'b1) @(posedge sys_clk);
      end
      repeat (4) @(posedge sys_clk);
    end
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    failures = failures + 1;
    test_done;
  end

  initial begin
    failures = 0;
    checks = 0;
    rst_n = 1'b0;
    run = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    raw = 10'h000;
    ramp = 10'h000;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk("config", `REG_CONFIG, 32'h0);
    rd_chk("interval", `REG_STEP_INTERVAL, {12'h0, `INTERVAL_MAX});
    rd_chk("unmapped", 8'h20, 32'h0);
    wr(`REG_LOAD_VALUE, 32'h155);
    rd_chk("load ro", `REG_LOAD_VALUE, 32'h0);
    wr(`REG_INT_ENABLE, 32'h1);
    rd_chk("enable", `REG_INT_ENABLE, 32'h1);
    wr(`REG_LOWER_LIMIT, 32'h100);
    wr(`REG_CONFIG, 32'h200);
    raw <= 10'd500;
    run <= 1'b1;
    steps(3);
    rd_chk("light load", `REG_LOAD_VALUE, 32'd500);
    raw <= 10'd700;
    steps(2);
    rd_chk("per step", `REG_LOAD_VALUE, 32'd700);
    wr(`REG_CONFIG, 32'h23f);
    steps(2);
    rd_chk("clamp top", `REG_LOAD_VALUE, 32'h3ff);
    raw <= 10'd500;
    steps(2);
    rd_chk("offset up", `REG_LOAD_VALUE, 32'd1004);
    wr(`REG_UPPER_LIMIT, 32'd50);
    raw <= 10'd300;
    wr(`REG_CONFIG, 32'h240);
    steps(3);
    rd_chk("heavy load", `REG_LOAD_VALUE, 32'h0);
    check("above upper", {stop_a, stop_b}, 2'b00);
    wr(`REG_LOWER_LIMIT, 32'd20);
    wr(`REG_UPPER_LIMIT, 32'h0);
    steps(3);
    check("below lower", {stop_a, stop_b}, 2'b00);
    wr(`REG_LOWER_LIMIT, 32'h100);
    repeat (100) @(posedge sys_clk);
    check("stall pin a", {stop_a, stop_b}, 2'b10);
    check("irq", irq, 1'b1);
    rd_chk("status", `REG_INT_STATUS, 32'h7);
    wr(`REG_INT_CLEAR, 32'h7);
    rd_chk("cleared", `REG_INT_STATUS, 32'h0);
    check("irq off", irq, 1'b0);
    wr(`REG_INT_ENABLE, 32'h0);
    wr(`REG_CONFIG, 32'h440);
    run <= 1'b0;
    @(posedge sys_clk);
    run <= 1'b1;
    repeat (200) @(posedge sys_clk);
    check("stall pin b", {stop_a, stop_b}, 2'b01);
    check("masked irq", irq, 1'b0);
    rd_chk("masked status", `REG_INT_STATUS, 32'h3);
    run <= 1'b0;
    wr(`REG_INT_CLEAR, 32'h7);
    wr(`REG_INT_ENABLE, 32'h2);
    wr(`REG_CONFIG, 32'h100);
    raw <= 10'd100;
    ramp <= 10'd100;
    run <= 1'b1;
    steps(10);
    rd_chk("filtered", `REG_LOAD_VALUE, 32'd250);
    check("update irq", irq, 1'b1);
    test_done;
  end
endmodule // motor_load_stall_detect_tb
